// ---- rtl/lct_cfg.svh ----
`ifndef LCT_CFG_SVH
`define LCT_CFG_SVH

// Register indexes; byte address is four times the index
`define LCT_IDX_LED_CTRL 16'h0025
`define LCT_IDX_COMPLIANCE_TEST_CONTROL 16'h0027
`define LCT_IDX_EXT_COMPLIANCE_TEST_CONTROL 16'h0428
`define LCT_ADDR_BITS 14

// Indicator control fields
`define LCT_LED_POL_BIT 9
`define LCT_LED_CFG_MSB 6
`define LCT_LED_CFG_LSB 3
`define LCT_LED_ROUTE_MSB 1
`define LCT_LED_ROUTE_LSB 0
`define LCT_ROUTE_COL 2'b00
`define LCT_ROUTE_LED0 2'b11

// Compliance fields
`define LCT_COMPLIANCE_TEST_CONTROL_TEN_EN_BIT 4
`define LCT_COMPLIANCE_TEST_CONTROL_PAT_MSB 3
`define LCT_COMPLIANCE_TEST_CONTROL_PAT_LSB 0
`define LCT_EXT_TX_EN_BIT 4
`define LCT_EXT_TX_HI_BIT 5

// Reset values
`define LCT_LED_CTRL_RST 16'h0000
`define LCT_COMPLIANCE_TEST_CONTROL_RST 16'h0000
`define LCT_EXT_COMPLIANCE_TEST_CONTROL_RST 16'h0000

// Timing
`define LCT_CLK_PERIOD_NS 8
`define LCT_BLINK_HALF_MS 40
`define LCT_BLINK_HALF_CYC ((`LCT_BLINK_HALF_MS * 1000000) / `LCT_CLK_PERIOD_NS)

`endif

// ---- rtl/lct_led_src.sv ----
`timescale 1ns/1ps
`include "lct_cfg.svh"

module lct_led_src
   import lct_pkg::*;
#(
   parameter int unsigned BLINK_HALF_CYC = `LCT_BLINK_HALF_CYC
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Selection and state
   input wire lct_src_e srcSel,
   input wire lct_status_s status,
   input wire logic bmcrRead,
   input wire logic selfTestErrClear,
   // Indication, true when the LED should be lit
   output logic ledActive
);

   logic [31:0] blinkCnt;
   logic blinkPhase;
   logic linkPrev;
   logic linkLost;
   logic testErr;

   ////////////////////////////////////////////////////////////////////////////
   // Blink timebase, free running so every blink mode shares one phase
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         blinkCnt <= 32'h00000000;
         blinkPhase <= 1'b0;
      end
      else if (blinkCnt >= BLINK_HALF_CYC - 1)
      begin
         blinkCnt <= 32'h00000000;
         blinkPhase <= ~blinkPhase;
      end
      else
      begin
         blinkCnt <= blinkCnt + 32'h00000001;
      end
   end

   // Link-lost latch; a drop in the read cycle wins over the clear
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         linkPrev <= 1'b0;
         linkLost <= 1'b0;
      end
      else
      begin
         linkPrev <= status.linkUp;
         if (linkPrev && !status.linkUp)
         begin
            linkLost <= 1'b1;
         end
         else if (bmcrRead)
         begin
            linkLost <= 1'b0;
         end
      end
   end

   // Test-error latch; a single error lights it until the count is cleared
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         testErr <= 1'b0;
      end
      else if (status.prbsErr)
      begin
         testErr <= 1'b1;
      end
      else if (selfTestErrClear)
      begin
         testErr <= 1'b0;
      end
   end

   // Source multiplexer
   always_comb
   begin
      case (srcSel)
         LCT_SRC_LINK: ledActive = status.linkUp;
         LCT_SRC_ACT: ledActive = status.rxAct | status.txAct;
         LCT_SRC_TX_ACT: ledActive = status.txAct;
         LCT_SRC_RX_ACT: ledActive = status.rxAct;
         LCT_SRC_COL: ledActive = status.collision;
         LCT_SRC_SPD100: ledActive = status.speed100;
         LCT_SRC_SPD10: ledActive = status.speed10;
         LCT_SRC_FDX: ledActive = status.fullDuplex;
         LCT_SRC_LINK_BLINK: ledActive = status.linkUp & ~((status.rxAct | status.txAct) & blinkPhase);
         LCT_SRC_STRETCH: ledActive = status.actStretch;
         LCT_SRC_MII_LINK: ledActive = status.linkUp & status.speed100 & status.fullDuplex;
         LCT_SRC_LPI: ledActive = status.lpiMode;
         LCT_SRC_MII_ERR: ledActive = status.miiErr;
         LCT_SRC_LINK_LOST: ledActive = linkLost;
         LCT_SRC_TEST_ERR: ledActive = testErr;
         default: ledActive = 1'b0; // Reserved code keeps the LED dark
      endcase
   end

endmodule

// ---- rtl/lct_pkg.sv ----
package lct_pkg;

   // Indicator source selection, in field code order
   typedef enum logic [3:0] {
      LCT_SRC_LINK, LCT_SRC_ACT, LCT_SRC_TX_ACT, LCT_SRC_RX_ACT,
      LCT_SRC_COL, LCT_SRC_SPD100, LCT_SRC_SPD10, LCT_SRC_FDX,
      LCT_SRC_LINK_BLINK, LCT_SRC_STRETCH, LCT_SRC_MII_LINK, LCT_SRC_LPI,
      LCT_SRC_MII_ERR, LCT_SRC_LINK_LOST, LCT_SRC_TEST_ERR, LCT_SRC_RSVD
   } lct_src_e;

   // 10BASE-Te pattern selection, in field code order
   typedef enum logic [3:0] {
      LCT_PAT_NLP, LCT_PAT_PULSE1, LCT_PAT_PULSE0, LCT_PAT_REP1,
      LCT_PAT_REP0, LCT_PAT_PREAMBLE, LCT_PAT_ONE_IDLE, LCT_PAT_ZERO_IDLE,
      LCT_PAT_1001, LCT_PAT_RANDOM, LCT_PAT_IDLE00, LCT_PAT_IDLE01,
      LCT_PAT_IDLE11, LCT_PAT_R13, LCT_PAT_R14, LCT_PAT_R15
   } lct_ten_pat_e;

   // Link state seen by the indicator logic
   typedef struct packed {
      logic linkUp;
      logic rxAct;
      logic txAct;
      logic collision;
      logic speed100;
      logic speed10;
      logic fullDuplex;
      logic actStretch;
      logic lpiMode;
      logic miiErr;
      logic prbsErr;
   } lct_status_s;

   // Test pattern command to the line transmitters
   typedef struct packed {
      logic tenEnable;
      lct_ten_pat_e tenPattern;
      logic txEnable;
      logic [4:0] txZeros;
   } lct_test_s;

   // Pin levels: collision pin and first indicator pin
   typedef struct packed {
      logic col;
      logic led0;
   } lct_pins_s;

endpackage

// ---- rtl/lct_test_sel.sv ----
`timescale 1ns/1ps
`include "lct_cfg.svh"

module lct_test_sel
   import lct_pkg::*;
(
   // Register contents
   input wire logic [15:0] compliance_test_control,
   input wire logic [15:0] extCompt,
   // Decoded test command
   output lct_test_s testCmd
);

   // Decode of the two compliance registers into one command
   always_comb
   begin
      testCmd.tenEnable = compliance_test_control[`LCT_COMPLIANCE_TEST_CONTROL_TEN_EN_BIT];
      testCmd.tenPattern = lct_ten_pat_e'(compliance_test_control[`LCT_COMPLIANCE_TEST_CONTROL_PAT_MSB:`LCT_COMPLIANCE_TEST_CONTROL_PAT_LSB]);
      testCmd.txEnable = extCompt[`LCT_EXT_TX_EN_BIT];
      testCmd.txZeros = {extCompt[`LCT_EXT_TX_HI_BIT], compliance_test_control[`LCT_COMPLIANCE_TEST_CONTROL_PAT_MSB:`LCT_COMPLIANCE_TEST_CONTROL_PAT_LSB]};
   end

endmodule

// ---- rtl/lct_top.sv ----
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "lct_cfg.svh"

module lct_top
   import lct_pkg::*;
#(
   parameter int unsigned BLINK_HALF_CYC = `LCT_BLINK_HALF_CYC
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Strap level on the indicator pin during reset
   input wire logic ledStrap,
   // Link state and management events
   input wire lct_status_s status,
   input wire logic bmcrRead,
   input wire logic selfTestErrClear,
   // Normal functions of the two shared pins
   input wire lct_pins_s pinNormal,
   // Pin levels and test command
   output lct_pins_s pinOut,
   output lct_test_s testCmd
);

   logic [15:0] ledCtrl;
   logic [15:0] compliance_test_control;
   logic [15:0] extCompt;
   logic strapDone;
   logic wrPend;
   logic rdPend;
   logic [`LCT_ADDR_BITS-1:0] dataIdx;
   logic ledActive;
   logic ledLevel;
   lct_test_s next_testCmd;
   lct_pins_s next_pinOut;
   logic addrAccept;
   logic [`LCT_ADDR_BITS-1:0] addrIdx;
   logic wrLed;
   logic wrCompt;
   logic wrExt;
   logic [31:0] next_hrdata;
   lct_src_e srcSel;
   logic ledPolHigh;
   logic [1:0] ledRoute;

   ////////////////////////////////////////////////////////////////////////////
   // Register index decode, shared by write and read paths
   function automatic logic [1:0] regSel(input logic [`LCT_ADDR_BITS-1:0] idx);
      logic [1:0] sel;
      sel = 2'h0;
      if (idx == `LCT_ADDR_BITS'(`LCT_IDX_LED_CTRL))
      begin
         sel = 2'h1;
      end
      else if (idx == `LCT_ADDR_BITS'(`LCT_IDX_COMPLIANCE_TEST_CONTROL))
      begin
         sel = 2'h2;
      end
      else if (idx == `LCT_ADDR_BITS'(`LCT_IDX_EXT_COMPLIANCE_TEST_CONTROL))
      begin
         sel = 2'h3;
      end
      return sel;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Address phase; only whole aligned words are meaningful
   assign addrAccept = hsel & htrans[1] & hready;
   assign addrIdx = haddr[`LCT_ADDR_BITS+1:2];

   // Bus timing as seen by a master:
   //   write: address edge, then the data phase ends at the next edge
   //   read: address edge, one wait cycle, then data with ready high
   // The read wait buys a registered read mux, so hrdata never comes
   // straight from the decode, and a write landing in the cycle before
   // a read is already visible in the read data

   // Data phase tracking
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wrPend <= 1'b0;
         rdPend <= 1'b0;
         dataIdx <= '0;
      end
      else if (addrAccept)
      begin
         wrPend <= hwrite;
         rdPend <= ~hwrite;
         dataIdx <= addrIdx;
      end
      else if (hreadyout)
      begin
         wrPend <= 1'b0;
         rdPend <= 1'b0;
      end
   end

   // Ready; low exactly one cycle per read
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         hreadyout <= 1'b1;
      end
      else if (addrAccept && !hwrite)
      begin
         hreadyout <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
      end
   end

   // Response; this slave never errors, so it only ever gives OKAY
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         hresp <= 1'b0;
      end
      else
      begin
         hresp <= 1'b0;
      end
   end

   // Write strobes for the data phase; at most one is high
   always_comb
   begin
      wrLed = 1'b0;
      wrCompt = 1'b0;
      wrExt = 1'b0;
      if (wrPend)
      begin
         case (regSel(dataIdx))
            2'h1: wrLed = 1'b1;
            2'h2: wrCompt = 1'b1;
            2'h3: wrExt = 1'b1;
            default: wrLed = 1'b0; // Unmapped word, write dropped
         endcase
      end
   end

   // Read mux; the upper half of every word reads as zero
   always_comb
   begin
      case (regSel(dataIdx))
         2'h1: next_hrdata = {16'h0000, ledCtrl};
         2'h2: next_hrdata = {16'h0000, compliance_test_control};
         2'h3: next_hrdata = {16'h0000, extCompt};
         default: next_hrdata = 32'h00000000;
      endcase
   end

   // Read data, captured in the wait cycle and held until the next read
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         hrdata <= 32'h00000000;
      end
      else if (rdPend && !hreadyout)
      begin
         hrdata <= next_hrdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Indicator control; polarity takes the inverted strap once, right after reset
   // release, so a late write from software is never overridden
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ledCtrl <= `LCT_LED_CTRL_RST;
         strapDone <= 1'b0;
      end
      else if (!strapDone)
      begin
         strapDone <= 1'b1;
         ledCtrl[`LCT_LED_POL_BIT] <= ~ledStrap;
      end
      else if (wrLed)
      begin
         ledCtrl <= hwdata[15:0];
      end
   end

   // Compliance register; software must force speed before changing it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         compliance_test_control <= `LCT_COMPLIANCE_TEST_CONTROL_RST;
      end
      else if (wrCompt)
      begin
         compliance_test_control <= hwdata[15:0];
      end
   end

   // Extended compliance register, kept here as plain storage
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         extCompt <= `LCT_EXT_COMPLIANCE_TEST_CONTROL_RST;
      end
      else if (wrExt)
      begin
         extCompt <= hwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fields of the indicator control word
   assign srcSel = lct_src_e'(ledCtrl[`LCT_LED_CFG_MSB:`LCT_LED_CFG_LSB]);
   assign ledPolHigh = ledCtrl[`LCT_LED_POL_BIT];
   assign ledRoute = ledCtrl[`LCT_LED_ROUTE_MSB:`LCT_LED_ROUTE_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // Indicator source selection and latches
   lct_led_src #(
      .BLINK_HALF_CYC(BLINK_HALF_CYC)
   ) uLedSrc (
      .mclk(mclk),
      .rst(rst),
      .srcSel(srcSel),
      .status(status),
      .bmcrRead(bmcrRead),
      .selfTestErrClear(selfTestErrClear),
      .ledActive(ledActive)
   );

   // Compliance test decode
   lct_test_sel uTestSel (
      .compliance_test_control(compliance_test_control),
      .extCompt(extCompt),
      .testCmd(next_testCmd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin level: lit level follows polarity, dark level is its inverse
   assign ledLevel = ledPolHigh ? ledActive : ~ledActive;

   // Routing; reserved codes leave both pins on their normal function
   always_comb
   begin
      next_pinOut = pinNormal;
      case (ledRoute)
         `LCT_ROUTE_COL: next_pinOut.col = ledLevel;
         `LCT_ROUTE_LED0: next_pinOut.led0 = ledLevel;
         default: next_pinOut = pinNormal;
      endcase
   end

   // Pin register; a status change reaches the pin one edge later, two for the link-lost and test-error latches
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pinOut <= '0;
      end
      else
      begin
         pinOut <= next_pinOut;
      end
   end

   // Test command register, one edge behind the compliance registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         testCmd <= '0;
      end
      else
      begin
         testCmd <= next_testCmd;
      end
   end

endmodule

// ---- sim/lct_checker_assertions.sv ----
`timescale 1ns/1ps
`include "lct_cfg.svh"

module lct_checker
   import lct_pkg::*;
#(
   parameter int unsigned BLINK_HALF_CYC = 4
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Pins and link state
   input wire logic ledStrap,
   input wire lct_status_s status,
   input wire logic bmcrRead,
   input wire logic selfTestErrClear,
   input wire lct_pins_s pinNormal,
   input wire lct_pins_s pinOut,
   input wire lct_test_s testCmd
);
   logic taken;
   logic wrPend;
   logic [15:0] wrIdx;
   logic [15:0] ledSh;
   logic [15:0] compSh;
   logic [15:0] extSh;
   logic ledKnown;
   logic [1:0] quiet;
   logic ok;
   logic lvl;
   logic [7:0] basic;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // Address phase capture
   assign taken = hsel & htrans[1] & hready;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         wrPend <= 1'b0;
      else
         wrPend <= taken & hwrite;
   end
   // Index taken from haddr at every edge, address phase or not; needs no reset
   always_ff @(posedge mclk)
   begin
      wrIdx <= {2'b00, haddr[15:2]};
   end
   // Register shadows; polarity is unknown until first written, strap decides it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ledSh <= 16'h0000;
         ledKnown <= 1'b0;
         compSh <= `LCT_COMPLIANCE_TEST_CONTROL_RST;
         extSh <= `LCT_EXT_COMPLIANCE_TEST_CONTROL_RST;
      end
      else if (wrPend && hready)
      begin
         ledKnown <= ledKnown | (wrIdx == `LCT_IDX_LED_CTRL);
         case (wrIdx)
            `LCT_IDX_LED_CTRL: ledSh <= hwdata[15:0];
            `LCT_IDX_COMPLIANCE_TEST_CONTROL: compSh <= hwdata[15:0];
            `LCT_IDX_EXT_COMPLIANCE_TEST_CONTROL: extSh <= hwdata[15:0];
            default: ;
         endcase
      end
   end
   // Cycles of calm inputs; the pin path is one edge deep
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         quiet <= 2'd0;
      else if ($stable(status) && $stable(pinNormal) && $stable(ledSh))
         quiet <= (quiet == 2'd3) ? 2'd3 : quiet + 2'd1;
      else
         quiet <= 2'd0;
   end
   // Expected level for the plain sources and the reserved code
   assign basic = {status.fullDuplex, status.speed10, status.speed100, status.collision,
                   status.rxAct, status.txAct, status.rxAct | status.txAct, status.linkUp};
   assign lvl = (ledSh[6] ? 1'b0 : basic[ledSh[5:3]]) ~^ ledSh[9];
   assign ok = ledKnown && quiet == 2'd3 && (!ledSh[6] || ledSh[6:3] == 4'hF);
   sequence calm;
      $stable(status) && $stable(pinNormal) && $stable(ledSh);
   endsequence
   ////////////////////////////////////////////////////////////
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("Bus response is not OKAY");
   a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
      else $error("Write inserted a wait state");
   a_read_one_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("Read wait state wrong");
   a_read_compliance_test_control_data: assert property (taken && !hwrite && {2'b00, haddr[15:2]} == `LCT_IDX_COMPLIANCE_TEST_CONTROL
      |-> ##2 hrdata == {16'h0000, compSh}) else $error("Compliance register read wrong");
   a_route_col_pin: assert property (calm ##0 (ok && ledSh[1:0] == 2'b00)
      |-> pinOut.col == lvl && pinOut.led0 == pinNormal.led0) else $error("Collision pin route wrong");
   a_route_led_pin: assert property (calm ##0 (ok && ledSh[1:0] == 2'b11)
      |-> pinOut.led0 == lvl && pinOut.col == pinNormal.col) else $error("Indicator pin route wrong");
   a_route_reserved: assert property (calm ##0 (ledKnown && quiet == 2'd3 && ledSh[1] != ledSh[0])
      |-> pinOut == pinNormal) else $error("Reserved route disturbed pins");
   a_test_cmd_map: assert property ($stable(compSh) && $stable(extSh)
      |-> testCmd == {compSh[4], compSh[3:0], extSh[4], extSh[5], compSh[3:0]}) else $error("Test command wrong");
   // Main scenarios reached
   c_read: cover property (taken && !hwrite);
   c_led_route: cover property (ok && ledSh[1:0] == 2'b11);
   c_ten_on: cover property (testCmd.tenEnable);
endmodule

bind lct_top lct_checker #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) chk_u (.mclk(mclk), .rst(rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ledStrap(ledStrap), .status(status),
   .bmcrRead(bmcrRead), .selfTestErrClear(selfTestErrClear), .pinNormal(pinNormal), .pinOut(pinOut),
   .testCmd(testCmd));

// ---- sim/lct_led_model.sv ----
`timescale 1ns/1ps

module lct_led_model
(
   // Pin level and how the LED is wired
   input wire logic pinLevel,
   input wire logic activeHigh,
   // Light seen by the observer
   output logic lit
);
   // An active-low LED sinks current, so a low pin lights it
   assign lit = activeHigh ? pinLevel : ~pinLevel;
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`include "lct_cfg.svh"

module tb_top
   import lct_pkg::*;
;
   logic mclk = 0;
   logic rst = 1;
   logic hsel = 0;
   logic hwrite = 0;
   logic ledStrap = 1;
   logic bmcrRead = 0;
   logic selfTestErrClear = 0;
   logic useLed0 = 0;
   logic pol = 0;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0;
   logic [31:0] hwdata = 0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout;
   logic hresp;
   logic lit;
   lct_status_s status = '0;
   lct_pins_s pinNormal = '0;
   lct_pins_s pinOut;
   lct_test_s testCmd;
   int err_count = 0;
   int tests_run = 0;
   ////////////////////////////////////////////////////////////
   // 125 MHz clock
   always #4 mclk = ~mclk;
   // Single slave, so its ready is the bus ready
   lct_top #(.BLINK_HALF_CYC(4)) dut_u (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ledStrap(ledStrap), .status(status), .bmcrRead(bmcrRead),
      .selfTestErrClear(selfTestErrClear), .pinNormal(pinNormal), .pinOut(pinOut), .testCmd(testCmd));
   lct_led_model led_u (.pinLevel(useLed0 ? pinOut.led0 : pinOut.col), .activeHigh(pol), .lit(lit));
   ////////////////////////////////////////////////////////////
   task close_out;
      $display("Counts: %0d errors in %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Ready is looked at before the edge so the sample never races the slave
   task rdy(output logic [31:0] d);
      logic r;
      int n;
      n = 0;
      do
      begin
         @(negedge mclk);
         r = hreadyout;
         d = hrdata;
         @(posedge mclk);
         n++;
      end
      while (r !== 1'b1 && n < 50);
      if (r !== 1'b1)
      begin
         $display("ERROR %0t: bus ready timeout", $time);
         err_count++;
         close_out();
      end
   endtask
   task xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {14'h0, idx, 2'b00};
      rdy(d);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      rdy(d);
   endtask
   task settle;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
   endtask
   task clr(input logic lost);
      @(posedge mclk);
      bmcrRead <= lost;
      selfTestErrClear <= ~lost;
      @(posedge mclk);
      bmcrRead <= 1'b0;
      selfTestErrClear <= 1'b0;
      settle();
   endtask
   function logic act(input logic [3:0] c, input lct_status_s s);
      case (c)
         4'h0, 4'h8: return s.linkUp;
         4'h1: return s.rxAct | s.txAct;
         4'h2: return s.txAct;
         4'h3: return s.rxAct;
         4'h4: return s.collision;
         4'h5: return s.speed100;
         4'h6: return s.speed10;
         4'h7: return s.fullDuplex;
         4'h9: return s.actStretch;
         4'hA: return s.linkUp & s.speed100 & s.fullDuplex;
         4'hB: return s.lpiMode;
         4'hC: return s.miiErr;
         default: return 1'b0;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////
   task do_reset(input logic s);
      @(posedge mclk);
      ledStrap <= s;
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      xfer(1'b0, `LCT_IDX_LED_CTRL, 0, rd);
      chk(rd[9], !s);
   endtask
   task s_regs;
      xfer(1'b0, `LCT_IDX_EXT_COMPLIANCE_TEST_CONTROL, 0, rd);
      chk(rd, 0);
      xfer(1'b1, `LCT_IDX_COMPLIANCE_TEST_CONTROL, 32'hABCD_0015, rd);
      xfer(1'b0, `LCT_IDX_COMPLIANCE_TEST_CONTROL, 0, rd);
      chk(rd, 32'h0000_0015);
      xfer(1'b0, 16'h0026, 0, rd);
      chk(rd, 0);
   endtask
   // Each source but link-lost and test-error seen alone with every other status bit quiet
   task s_src;
      for (int c = 0; c < 16; c++)
      begin
         if (c == 13 || c == 14)
            continue;
         xfer(1'b1, `LCT_IDX_LED_CTRL, {22'h0, c[1], 2'b00, c[3:0], 1'b0, c[0], c[0]}, rd);
         useLed0 <= c[0];
         pol <= c[1];
         for (int b = 0; b < 11; b++)
         begin
            @(posedge mclk);
            status <= lct_status_s'(11'h001 << b);
            pinNormal <= lct_pins_s'({b[0], ~b[0]});
            settle();
            chk(lit, act(c[3:0], status));
            chk(c[0] ? pinOut.col : pinOut.led0, c[0] ? pinNormal.col : pinNormal.led0);
         end
      end
   endtask
   task s_route;
      for (int b = 0; b < 4; b++)
      begin
         xfer(1'b1, `LCT_IDX_LED_CTRL, {30'h0, b[1], ~b[1]}, rd);
         pinNormal <= lct_pins_s'(b[1:0]);
         settle();
         chk(pinOut, b[1:0]);
      end
   endtask
   task s_lost;
      xfer(1'b1, `LCT_IDX_LED_CTRL, 32'h0000_026B, rd);
      useLed0 <= 1'b1;
      pol <= 1'b1;
      status <= lct_status_s'(11'h400);
      clr(1'b1);
      chk(lit, 1'b0);
      @(posedge mclk);
      status <= '0;
      settle();
      chk(lit, 1'b1);
      @(posedge mclk);
      status <= lct_status_s'(11'h400);
      clr(1'b0);
      chk(lit, 1'b1);
      clr(1'b1);
      chk(lit, 1'b0);
   endtask
   task s_err;
      xfer(1'b1, `LCT_IDX_LED_CTRL, 32'h0000_0273, rd);
      status <= '0;
      clr(1'b0);
      chk(lit, 1'b0);
      @(posedge mclk);
      status <= lct_status_s'(11'h001);
      @(posedge mclk);
      status <= '0;
      settle();
      chk(lit, 1'b1);
      clr(1'b1);
      chk(lit, 1'b1);
      clr(1'b0);
      chk(lit, 1'b0);
   endtask
   // Blink on activity: dark for one half period in every full period
   task s_blink;
      int on;
      on = 0;
      xfer(1'b1, `LCT_IDX_LED_CTRL, 32'h0000_0243, rd);
      useLed0 <= 1'b1;
      pol <= 1'b1;
      status <= lct_status_s'(11'h600);
      settle();
      repeat (16)
      begin
         @(negedge mclk);
         on += lit;
      end
      chk(on, 8);
      @(posedge mclk);
      status <= lct_status_s'(11'h400);
      settle();
      chk(lit, 1'b1);
   endtask
   // Speed is taken as already forced; repetitive patterns are only decoded, never measured
   task s_test;
      for (int p = 0; p < 16; p++)
      begin
         xfer(1'b1, `LCT_IDX_EXT_COMPLIANCE_TEST_CONTROL, {26'h0, p[1], p[2], 4'h0}, rd);
         xfer(1'b1, `LCT_IDX_COMPLIANCE_TEST_CONTROL, {27'h0, p[0], p[3:0]}, rd);
         settle();
         chk(testCmd, {p[0], p[3:0], p[2], p[1], p[3:0]});
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      do_reset(1'b1);
      s_regs();
      s_src();
      s_route();
      s_lost();
      s_err();
      s_blink();
      s_test();
      do_reset(1'b0);
      close_out();
   end
endmodule
